// file: include/sld_pkg.sv
// Package for the third-level second-stage entry decoder
package sld_pkg;
    // Entry bit positions
    localparam int BIT_READ     = 0;
    localparam int BIT_WRITE    = 1;
    localparam int BIT_EXEC     = 2;
    localparam int EMT_LO       = 3;
    localparam int EMT_HI       = 5;
    localparam int BIT_IGNORE_ATTR_TABLE     = 6;
    localparam int BIT_SIZE     = 7;
    localparam int BIT_ACCESSED = 8;
    localparam int BIT_DIRTY    = 9;
    localparam int BIT_SNOOP    = 11;
    localparam int BIT_RSV62    = 62;
    localparam int RSV_TOP      = 51;
    localparam int LEAF_LO      = 30;
    localparam int DIR_LO       = 12;
    localparam int LEAF_RSV_HI  = 29;
    localparam int PA_W         = 52;
    // Table mode and walk type codes
    localparam logic [1:0] TM_LEGACY     = 2'h0;
    localparam logic [2:0] WT_SS_ONLY    = 3'h2;
    localparam logic [2:0] WT_NESTED     = 3'h3;
    // Memory type codes
    localparam logic [2:0] MT_UC = 3'h0;
    localparam logic [2:0] MT_WC = 3'h1;
    localparam logic [2:0] MT_WT = 3'h4;
    localparam logic [2:0] MT_WP = 3'h5;
    localparam logic [2:0] MT_WB = 3'h6;
    // Register offsets (byte addresses)
    localparam logic [3:0] ADR_CTRL   = 4'h0;
    localparam logic [3:0] ADR_STATUS = 4'h4;
    localparam logic [3:0] ADR_MASK   = 4'h8;
    localparam logic [3:0] ADR_LAST   = 4'hc;
    // Control register fields
    localparam int CTL_LPS = 0;
    localparam int CTL_ZLR = 1;
    // Status bits
    localparam int ST_DONE  = 0;
    localparam int ST_FAULT = 1;
    localparam int ST_W     = 2;

    // Request from the walker
    typedef struct packed {
        logic [63:0] entry;
        logic        ad_enable;
        logic        emt_enable;
        logic [1:0]  table_mode;
        logic [2:0]  walk_type;
        logic        exec_enable;
        logic        coherent;
        logic        is_read;
        logic        is_write;
        logic        is_exec;
        logic        zero_len;
        logic        prev_r;
        logic        prev_w;
        logic        prev_x;
    } sld_req_type;

    // Decoded answer
    typedef struct packed {
        logic             fault;
        logic             leaf;
        logic [PA_W-1:0]  base;
        logic             perm_r;
        logic             perm_w;
        logic             perm_x;
        logic             allowed;
        logic             mark_acc;
        logic             mark_dirty;
        logic             use_emt;
        logic [2:0]       mem_type;
        logic             mt_reserved;
        logic             use_attr_table;
    } sld_rsp_type;
endpackage : sld_pkg

// file: design/sld_mask_gen.sv
// Reserved-bit mask generator for a given host address width
`timescale 1ns/1ps
`default_nettype none
module sld_mask_gen
    import sld_pkg::*;
#(
    parameter int HOST_ADDR_WIDTH = 48
) (
    // Mask outputs
    output logic [63:0] hi_rsv_o,
    output logic [63:0] addr_leaf_o,
    output logic [63:0] addr_dir_o
);
    // One bit per position
    for (genvar b = 0; b < 64; b++) begin : g_bit
        assign hi_rsv_o[b]    = (b >= HOST_ADDR_WIDTH) && (b <= RSV_TOP);
        assign addr_leaf_o[b] = (b >= LEAF_LO) && (b < HOST_ADDR_WIDTH);
        assign addr_dir_o[b]  = (b >= DIR_LO) && (b < HOST_ADDR_WIDTH);
    end
endmodule : sld_mask_gen
`default_nettype wire

// file: design/sld_mt_decode.sv
// Memory type decoder
`timescale 1ns/1ps
`default_nettype none
module sld_mt_decode
    import sld_pkg::*;
(
    // Code in, reserved flag out
    input  wire logic [2:0] code_i,
    output logic            reserved_o
);
    // Legal codes only
    always_comb begin
        case (code_i)
            MT_UC, MT_WC, MT_WT, MT_WP, MT_WB: reserved_o = 1'b0;
            default:                           reserved_o = 1'b1;
        endcase
    end
endmodule : sld_mt_decode
`default_nettype wire

// file: design/sld_decoder.sv
// Third-level second-stage page-table entry decoder with Wishbone registers
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sld_decoder
    import sld_pkg::*;
#(
    parameter int HOST_ADDR_WIDTH = 48
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Walker request and answer
    input  wire logic        req_valid_i,
    input  var  sld_req_type req_i,
    output logic             rsp_valid_o,
    output sld_rsp_type      rsp_o,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Interrupt
    output logic             irq_o
);
    // Width check
    initial begin
        if (HOST_ADDR_WIDTH < 31 || HOST_ADDR_WIDTH > 52) $error("sld_decoder: HOST_ADDR_WIDTH out of range");
    end

    logic [63:0] hi_rsv;
    logic [63:0] addr_leaf;
    logic [63:0] addr_dir;
    logic        mt_rsv;
    logic [1:0]  ctrl_reg;
    logic [2:0]  status_reg;
    logic [2:0]  mask_reg;
    logic [31:0] last_reg;
    sld_rsp_type rsp_next;
    logic [2:0]  ev;

    // Mask generator
    sld_mask_gen #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH)) u_mask (
        .hi_rsv_o    (hi_rsv),
        .addr_leaf_o (addr_leaf),
        .addr_dir_o  (addr_dir)
    );

    // Memory type checker
    sld_mt_decode u_mt (
        .code_i     (req_i.entry[EMT_HI:EMT_LO]),
        .reserved_o (mt_rsv)
    );

    // Combinational decode of one entry
    always_comb begin
        logic [63:0] e;
        logic        lps;
        logic        leaf;
        logic        rsv_bad;
        logic        typing;
        logic        rd_ok;
        logic        wr_ok;
        logic        ex_ok;
        e        = req_i.entry;
        lps      = ctrl_reg[CTL_LPS];
        rsp_next = '0;
        // Size bit selects form only with large-page support
        leaf     = lps && e[BIT_SIZE];
        rsv_bad  = e[BIT_RSV62] || |(e & hi_rsv);
        if (!lps && e[BIT_SIZE]) begin
            rsv_bad = 1'b1;
        end
        if (leaf) begin
            rsv_bad = rsv_bad || |e[LEAF_RSV_HI:DIR_LO];
            rsp_next.base = e[PA_W-1:0] & addr_leaf[PA_W-1:0];
        end else begin
            rsv_bad = rsv_bad || e[BIT_SNOOP];
            rsp_next.base = e[PA_W-1:0] & addr_dir[PA_W-1:0];
        end
        rsp_next.leaf  = leaf;
        rsp_next.fault = rsv_bad;
        // Permissions, combined with upper levels
        rsp_next.perm_r = e[BIT_READ] && req_i.prev_r;
        rsp_next.perm_w = e[BIT_WRITE] && req_i.prev_w;
        rsp_next.perm_x = (!req_i.exec_enable || e[BIT_EXEC]) && req_i.prev_x;
        rd_ok = rsp_next.perm_r
             || (ctrl_reg[CTL_ZLR] && req_i.zero_len && rsp_next.perm_w);
        wr_ok = rsp_next.perm_w;
        ex_ok = rsp_next.perm_x;
        rsp_next.allowed = !rsv_bad
             && (!req_i.is_read || rd_ok)
             && (!req_i.is_write || wr_ok)
             && (!req_i.is_exec || ex_ok);
        // Access and dirty marking
        rsp_next.mark_acc   = req_i.ad_enable && rsp_next.allowed;
        rsp_next.mark_dirty = req_i.ad_enable && leaf && rsp_next.allowed
             && req_i.is_write;
        // Memory typing
        typing = req_i.emt_enable && (req_i.table_mode != TM_LEGACY);
        rsp_next.use_emt = typing && leaf && req_i.coherent
             && (req_i.walk_type == WT_SS_ONLY || req_i.walk_type == WT_NESTED);
        rsp_next.mem_type    = rsp_next.use_emt ? e[EMT_HI:EMT_LO] : MT_UC;
        rsp_next.mt_reserved = rsp_next.use_emt && mt_rsv;
        rsp_next.use_attr_table = !(typing && leaf && req_i.coherent
             && req_i.walk_type == WT_NESTED && e[BIT_IGNORE_ATTR_TABLE]);
    end

    // Answer register, one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_o       <= '0;
        end else begin
            rsp_valid_o <= req_valid_i;
            if (req_valid_i) begin
                rsp_o <= rsp_next;
            end
        end
    end

    // Events from a decoded entry
    assign ev[ST_DONE]  = req_valid_i;
    assign ev[ST_FAULT] = req_valid_i && rsp_next.fault;
    assign ev[ST_W]     = req_valid_i && rsp_next.mt_reserved;

    logic wb_hit;
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Wishbone ack, one wait state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
        end
    end

    // Control and mask writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= 2'h0;
            mask_reg <= 3'h0;
        end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == ADR_CTRL) begin
                ctrl_reg <= wb_dat_i[1:0];
            end else if (wb_adr_i == ADR_MASK) begin
                mask_reg <= wb_dat_i[2:0];
            end
        end
    end

    // Sticky status, set wins over write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= 3'h0;
        end else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_STATUS) begin
            status_reg <= (status_reg & ~wb_dat_i[2:0]) | ev;
        end else begin
            status_reg <= status_reg | ev;
        end
    end

    // Last decoded entry low word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_reg <= 32'h0;
        end else if (req_valid_i) begin
            last_reg <= req_i.entry[31:0];
        end
    end

    // Read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (wb_hit && !wb_we_i) begin
            if (wb_adr_i == ADR_CTRL) begin
                wb_dat_o <= {30'h0, ctrl_reg};
            end else if (wb_adr_i == ADR_STATUS) begin
                wb_dat_o <= {29'h0, status_reg};
            end else if (wb_adr_i == ADR_MASK) begin
                wb_dat_o <= {29'h0, mask_reg};
            end else if (wb_adr_i == ADR_LAST) begin
                wb_dat_o <= last_reg;
            end else begin
                wb_dat_o <= 32'h0;
            end
        end
    end

    // Interrupt level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |((status_reg | ev) & mask_reg);
        end
    end

    // Checks
    a_fault_on_rsv: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && req_i.entry[BIT_RSV62] |=> rsp_valid_o && rsp_o.fault)
        else $error("reserved bit 62 did not fault");
    a_write_denied: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && !req_i.entry[BIT_WRITE] |=> !rsp_o.perm_w)
        else $error("write granted with bit 1 clear");
    a_read_denied: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && !req_i.entry[BIT_READ] |=> !rsp_o.perm_r)
        else $error("read granted with bit 0 clear");
    a_exec_denied: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && req_i.exec_enable && !req_i.entry[BIT_EXEC] |=> !rsp_o.perm_x)
        else $error("exec granted with bit 2 clear");
    a_leaf_needs_lps: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && !ctrl_reg[CTL_LPS] |=> !rsp_o.leaf)
        else $error("leaf without large-page support");
    a_leaf_size: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && ctrl_reg[CTL_LPS] |=> rsp_o.leaf == $past(req_i.entry[BIT_SIZE]))
        else $error("leaf flag mismatch");
    a_legacy_no_emt: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && req_i.table_mode == TM_LEGACY |=> !rsp_o.use_emt && rsp_o.use_attr_table)
        else $error("typing used in legacy mode");
    a_acc_off: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && !req_i.ad_enable |=> !rsp_o.mark_acc && !rsp_o.mark_dirty)
        else $error("access marked with tracking off");
    a_ignore_attr_table_nested: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && req_i.walk_type != WT_NESTED |=> rsp_o.use_attr_table)
        else $error("attr table skipped outside nested walk");
    a_upper_deny: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && !req_i.prev_w |=> !rsp_o.perm_w)
        else $error("upper-level write denial lost");
    c_leaf: cover property (@(posedge clk_i) rsp_valid_o && rsp_o.leaf && rsp_o.allowed);
    c_dir: cover property (@(posedge clk_i) rsp_valid_o && !rsp_o.leaf && rsp_o.allowed);
    c_fault: cover property (@(posedge clk_i) rsp_valid_o && rsp_o.fault);
    c_irq: cover property (@(posedge clk_i) irq_o);
endmodule : sld_decoder
`default_nettype wire

// file: test/sld_walker_model.sv
// Walker model that issues entry decode requests and collects answers
`timescale 1ns/1ps
`default_nettype none
module sld_walker_model
    import sld_pkg::*;
(
    // Clock
    input  wire logic        clk_i,
    // Request to the decoder
    output logic             req_valid_o,
    output sld_req_type      req_o,
    // Answer from the decoder
    input  wire logic        rsp_valid_i,
    input  var  sld_rsp_type rsp_i
);
    sld_req_type q[$];
    sld_rsp_type got[$];

    // Idle request lines from time zero
    initial begin
        req_valid_o = 1'b0;
        req_o       = '0;
    end

    // Keep every answer seen on a sampling edge
    always @(posedge clk_i) begin
        if (rsp_valid_i === 1'b1) begin
            got.push_back(rsp_i);
        end
    end

    // Send queued entries gap idle cycles apart, then let answers land
    task run(input int gap);
        while (q.size() > 0) begin
            @(posedge clk_i);
            req_valid_o <= 1'b1;
            req_o       <= q.pop_front();
            repeat (gap) begin
                @(posedge clk_i);
                req_valid_o <= 1'b0;
            end
        end
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : run
endmodule : sld_walker_model
`default_nettype wire

// file: test/sld_decoder_tb.sv
// Self-checking bench for the entry decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; \
    $display("BAD %s exp %0h got %0h", n, e, a); end end
module sld_decoder_tb
    import sld_pkg::*;
;
    localparam logic [63:0] PG = 64'h0000_8000_4000_0000; // Base bits 47 and 30
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req_valid;
    logic        rsp_valid;
    sld_req_type req;
    sld_rsp_type rsp;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        irq;
    logic [31:0] d;
    sld_req_type r;
    sld_rsp_type s;
    int          num_errors = 0;
    int          checked = 0;
    int          lp[5] = '{12, 29, 48, 51, 62};
    int          dp[3] = '{11, 48, 62};
    logic [7:0]  cfg[5] = '{8'h1e, 8'h57, 8'h4e, 8'h5a, 8'h5c};

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    // Decoder and the walker in front of it
    sld_decoder #(.HOST_ADDR_WIDTH(48)) dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid),
        .req_i(req), .rsp_valid_o(rsp_valid), .rsp_o(rsp), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq));
    sld_walker_model walker (.clk_i(clk_i), .req_valid_o(req_valid), .req_o(req),
        .rsp_valid_i(rsp_valid), .rsp_i(rsp));

    // Verdict and end of run
    task summarize;
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // One classic bus cycle, ack awaited under a bound
    task wb(input logic w, input logic [3:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hf;
        wdat <= v;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        d = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            summarize();
        end
    endtask : wb

    // Read and compare
    task rd(input logic [3:0] a, input logic [31:0] e, input string n);
        wb(1'b0, a, 32'h0);
        `CHK(n, e, d)
    endtask : rd

    // Request with open context: nested, coherent, exec check on
    function automatic sld_req_type mk(input logic [63:0] e, input logic [2:0] xwr);
        sld_req_type t;
        t = '0;
        t.entry = e;
        t.table_mode = 2'h1;
        t.walk_type = WT_NESTED;
        t.exec_enable = 1'b1;
        t.coherent = 1'b1;
        {t.is_exec, t.is_write, t.is_read} = xwr;
        {t.prev_x, t.prev_w, t.prev_r} = 3'h7;
        return t;
    endfunction : mk

    // One decode, answer into s
    task dec(input sld_req_type x);
        walker.q.push_back(x);
        walker.run(0);
        s = walker.got.pop_front();
    endtask : dec

    // Reset values, unmapped write, read back
    task s_regs;
        wb(1'b1, 4'h2, 32'hffff_ffff);
        rd(4'h2, 32'h0, "unmapped");
        rd(ADR_CTRL, 32'h0, "ctrl");
        rd(ADR_STATUS, 32'h0, "status");
        rd(ADR_MASK, 32'h0, "mask");
        wb(1'b1, ADR_CTRL, 32'h3);
        rd(ADR_CTRL, 32'h3, "ctrl rw");
    endtask : s_regs

    // Leaf and directory forms, ignored and reserved bits
    task s_form;
        dec(mk(PG | 64'hbff0_0000_0000_0087, 3'h7));
        `CHK("leaf", 1'b1, s.leaf)
        `CHK("leaf ok", 1'b0, s.fault)
        `CHK("leaf base", 52'h8000_4000_0000, s.base)
        foreach (lp[i]) begin
            dec(mk(PG | 64'h87 | (64'h1 << lp[i]), 3'h1));
            `CHK("leaf rsv", 1'b1, s.fault)
            `CHK("rsv deny", 1'b0, s.allowed)
        end
        dec(mk(PG | 64'hbff0_0000_0000_167f, 3'h7));
        `CHK("dir", 1'b0, s.leaf)
        `CHK("dir ok", 1'b0, s.fault)
        `CHK("dir base", 52'h8000_4000_1000, s.base)
        foreach (dp[i]) begin
            dec(mk(PG | 64'h1007 | (64'h1 << dp[i]), 3'h1));
            `CHK("dir rsv", 1'b1, s.fault)
        end
    endtask : s_form

    // Permission checks and combination with upper levels
    task s_perm;
        dec(mk(PG | 64'h81, 3'h2));
        `CHK("w deny", 1'b0, s.allowed)
        `CHK("perm w", 1'b0, s.perm_w)
        r = mk(PG | 64'h81, 3'h4);
        dec(r);
        `CHK("x deny", 1'b0, s.allowed)
        r.exec_enable = 1'b0;
        dec(r);
        `CHK("x off", 1'b1, s.allowed)
        dec(mk(PG | 64'h86, 3'h1));
        `CHK("r deny", 1'b0, s.allowed)
        r = mk(PG | 64'h87, 3'h1);
        r.prev_r = 1'b0;
        dec(r);
        `CHK("upper r", 1'b0, s.perm_r)
        r = mk(PG | 64'h82, 3'h1);
        r.zero_len = 1'b1;
        dec(r);
        `CHK("zlr", 1'b1, s.allowed)
        wb(1'b1, ADR_CTRL, 32'h1);
        dec(r);
        `CHK("zlr off", 1'b0, s.allowed)
    endtask : s_perm

    // Access and dirty marks
    task s_mark;
        r = mk(PG | 64'h87, 3'h2);
        r.ad_enable = 1'b1;
        dec(r);
        `CHK("acc", 1'b1, s.mark_acc)
        `CHK("dirty", 1'b1, s.mark_dirty)
        r.entry = PG | 64'h1007;
        dec(r);
        `CHK("dir dirty", 1'b0, s.mark_dirty)
        r = mk(PG | 64'h87, 3'h2);
        dec(r);
        `CHK("acc off", 1'b0, s.mark_acc)
        `CHK("dirty off", 1'b0, s.mark_dirty)
    endtask : s_mark

    // Memory type codes back to back, enables spaced out
    task s_emt;
        for (int c = 0; c < 8; c++) begin
            r = mk(PG | 64'h87 | (64'(c) << 3), 3'h1);
            r.emt_enable = 1'b1;
            walker.q.push_back(r);
        end
        walker.run(0);
        `CHK("answers", 8, walker.got.size())
        for (int c = 0; c < 8; c++) begin
            s = walker.got.pop_front();
            `CHK("mem type", 3'(c), s.mem_type)
            `CHK("mt rsv", logic'(c inside {2, 3, 7}), s.mt_reserved)
            `CHK("attr used", 1'b1, s.use_attr_table)
        end
        foreach (cfg[i]) begin
            r = mk(PG | 64'hf7, 3'h1);
            {r.table_mode, r.walk_type, r.coherent, r.emt_enable} = cfg[i][7:1];
            walker.q.push_back(r);
        end
        walker.run(2);
        foreach (cfg[i]) begin
            s = walker.got.pop_front();
            `CHK("use emt", cfg[i][0], s.use_emt)
            `CHK("mt idle", cfg[i][0] ? MT_WB : MT_UC, s.mem_type)
            if (cfg[i][0]) `CHK("ignore_attr_table ss", 1'b1, s.use_attr_table)
        end
        r = mk(PG | 64'hf7, 3'h1);
        r.emt_enable = 1'b1;
        dec(r);
        `CHK("ignore_attr_table", 1'b0, s.use_attr_table)
    endtask : s_emt

    // Fault event, status, mask and interrupt
    task s_irq;
        wb(1'b1, ADR_STATUS, 32'h7);
        rd(ADR_STATUS, 32'h0, "st clr");
        wb(1'b1, ADR_MASK, 32'h2);
        wb(1'b1, ADR_CTRL, 32'h0);
        dec(mk(PG | 64'h87, 3'h1));
        `CHK("no lps", 1'b1, s.fault)
        rd(ADR_STATUS, 32'h3, "st ev");
        `CHK("irq", 1'b1, irq)
        rd(ADR_LAST, 32'h4000_0087, "last");
        wb(1'b1, ADR_STATUS, 32'h2);
        rd(ADR_STATUS, 32'h1, "st w1c");
        `CHK("irq clr", 1'b0, irq)
    endtask : s_irq

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        s_regs();
        s_form();
        s_perm();
        s_mark();
        s_emt();
        s_irq();
        summarize();
    end
endmodule : sld_decoder_tb
`default_nettype wire
